// *** core/clip_led_and_frontend_status.sv ***
`timescale 1ns/1ps
module clip_led_and_frontend_status #(
  parameter int unsigned STRETCH = clip_status_pkg::STRETCH_CYCLES,
  parameter int unsigned SETUP = clip_status_pkg::SETUP_CYCLES,
  parameter int unsigned DIV = clip_status_pkg::SOCKET_DIV
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Host reset, asynchronous, active high
  input wire logic host_async_reset_in,
  // Requests from user logic, asynchronous
  input wire clip_status_pkg::led_pair_type activity_request_in,
  // Fault conditions, same clock domain
  input wire clip_status_pkg::fault_set_type fault_in,
  // Reserved handshake from user logic, socket clock domain
  input wire logic frontend_setup_ready_in,
  // Front panel indicator
  output clip_status_pkg::led_pair_type activity_led_out,
  // To user logic
  output logic socket_clock_out,
  output logic frontend_setup_complete_out,
  output logic frontend_setup_prepare_out,
  output logic frontend_setup_ready_seen_out
);

  localparam int unsigned SW = $clog2(STRETCH + 1);
  localparam int unsigned UW = $clog2(SETUP + 1);
  localparam int unsigned DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [DW-1:0] DIV_HIGH = DW'(DIV / 2);
  localparam logic [SW-1:0] STRETCH_LOAD = SW'(STRETCH);
  localparam logic [UW-1:0] SETUP_LAST = UW'(SETUP - 1);

  // Refuse values the counters cannot serve
  if (DIV < 2 || STRETCH < 1 || SETUP < 1) begin : g_bad_param
    $error("clip_led_and_frontend_status: bad parameter");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] host_rst_meta;
  logic host_rst_s;
  logic host_rst_d;
  logic [1:0] req_meta;
  logic [1:0] req_s;
  logic [1:0] req_d;
  logic ready_meta;
  logic ready_s;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_rst_meta <= 2'h3;
      host_rst_s <= 1'h1;
      host_rst_d <= 1'h1;
    end else if (ce_in) begin
      host_rst_meta <= {host_rst_meta[0], host_async_reset_in};
      host_rst_s <= host_rst_meta[1];
      host_rst_d <= host_rst_s;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_meta <= 2'h0;
      req_s <= 2'h0;
      req_d <= 2'h0;
      ready_meta <= 1'h0;
      ready_s <= 1'h0;
    end else if (ce_in) begin
      // Two flops catch any request held 25 ns or one socket cycle
      req_meta <= activity_request_in;
      req_s <= req_meta;
      req_d <= req_s;
      ready_meta <= frontend_setup_ready_in;
      ready_s <= ready_meta;
    end
  end

  // ----------------------------------------------------------------
  // Fault override
  // ----------------------------------------------------------------
  logic override;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      override <= 1'h0;
    else if (ce_in)
      override <= |fault_in;
  end

  // ----------------------------------------------------------------
  // Pulse stretchers
  // ----------------------------------------------------------------
  logic [1:0] led;
  logic [1:0][SW-1:0] stretch_cnt;

  for (genvar i = 0; i < clip_status_pkg::LED_COUNT; i++) begin : g_led
    logic rise;
    logic [SW-1:0] next_cnt;
    logic forced;
    assign rise = req_s[i] && !req_d[i];
    assign next_cnt = rise ? STRETCH_LOAD : (stretch_cnt[i] != '0 ? stretch_cnt[i] - SW'(1) : '0);
    // Faults force red on and green off until they clear
    assign forced = (i == clip_status_pkg::RED_IDX);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        stretch_cnt[i] <= '0;
        led[i] <= 1'h0;
      end else if (ce_in) begin
        stretch_cnt[i] <= next_cnt;
        if (override)
          led[i] <= forced;
        else
          led[i] <= req_s[i] || (next_cnt != '0);
      end
    end

    led_follows_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
      $rose(req_s[i]) && !override |=> led[i] && stretch_cnt[i] == STRETCH_LOAD)
      else $error("stretcher did not load on a new request");
    led_holds_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
      (stretch_cnt[i] > SW'(1)) && !override && !$rose(override) ##1 !override |-> led[i])
      else $error("indicator dark while stretch count runs");
    led_idle_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
      !req_s[i] && stretch_cnt[i] == '0 && !override |=> !led[i])
      else $error("indicator lit with no cause");
  end

  assign activity_led_out = led;

  override_red_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    override |=> led[clip_status_pkg::RED_IDX] && !led[clip_status_pkg::GREEN_IDX])
    else $error("fault override not shown");

  // ----------------------------------------------------------------
  // Socket clock divider
  // ----------------------------------------------------------------
  logic [DW-1:0] div_cnt;
  logic [DW-1:0] next_div;
  assign next_div = (div_cnt == DIV_LAST) ? '0 : div_cnt + DW'(1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= '0;
      socket_clock_out <= 1'h0;
    end else if (ce_in) begin
      div_cnt <= next_div;
      socket_clock_out <= (next_div < DIV_HIGH);
    end
  end

  socket_wrap_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    div_cnt == DIV_LAST |=> socket_clock_out && div_cnt == '0 ##1 div_cnt == DW'(1))
    else $error("socket clock period wrong");

  // ----------------------------------------------------------------
  // Power-on self-setup sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SETUP_HELD, SETUP_RUN, SETUP_DONE} setup_state_type;
  setup_state_type setup_state;
  logic [UW-1:0] setup_cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setup_state <= SETUP_HELD;
      setup_cnt <= '0;
      frontend_setup_complete_out <= 1'h0;
    end else if (ce_in) begin
      if (host_rst_s) begin
        setup_state <= SETUP_HELD;
        setup_cnt <= '0;
        frontend_setup_complete_out <= 1'h0;
      end else begin
        unique case (setup_state)
          SETUP_HELD: begin
            // Release edge starts a fresh pass unconditionally
            if (host_rst_d)
              setup_state <= SETUP_RUN;
            setup_cnt <= '0;
          end
          SETUP_RUN: begin
            if (setup_cnt == SETUP_LAST) begin
              setup_state <= SETUP_DONE;
              frontend_setup_complete_out <= 1'h1;
            end else begin
              setup_cnt <= setup_cnt + UW'(1);
            end
          end
          SETUP_DONE: begin
            frontend_setup_complete_out <= 1'h1;
          end
        endcase
      end
    end
  end

  // Reserved handshake: prepare held low, loopback result reported
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frontend_setup_prepare_out <= 1'h0;
      frontend_setup_ready_seen_out <= 1'h0;
    end else if (ce_in) begin
      frontend_setup_prepare_out <= 1'h0;
      frontend_setup_ready_seen_out <= ready_s;
    end
  end

  complete_reset_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    host_rst_s |=> !frontend_setup_complete_out)
    else $error("setup complete high during host reset");
  complete_rise_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    $rose(frontend_setup_complete_out) |-> $past(setup_cnt) == SETUP_LAST && $past(setup_state) == SETUP_RUN)
    else $error("setup complete rose before the pass ended");
  complete_holds_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    frontend_setup_complete_out && !host_rst_s |=> frontend_setup_complete_out)
    else $error("setup complete dropped without host reset");
  release_restart_a: assert property (@(posedge clk_in iff ce_in) disable iff (!rst_n_in)
    $fell(host_rst_s) |=> setup_state == SETUP_RUN && setup_cnt == '0)
    else $error("host reset release did not start a pass");

endmodule

// *** core/clip_status_pkg.sv ***
package clip_status_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SOCKET_HZ = 40_000_000;
  localparam int unsigned STRETCH_MS = 100;
  localparam int unsigned SETUP_NS = 1000;
  localparam int unsigned STRETCH_CYCLES = (CLK_HZ / 1000) * STRETCH_MS;
  localparam int unsigned SETUP_CYCLES = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SOCKET_DIV = CLK_HZ / SOCKET_HZ;

  // ----------------------------------------------------------------
  // Indicator channels
  // ----------------------------------------------------------------
  localparam int unsigned LED_COUNT = 2;
  localparam int unsigned RED_IDX = 0;
  localparam int unsigned GREEN_IDX = 1;

  typedef struct packed {
    logic green;
    logic red;
  } led_pair_type;

  typedef struct packed {
    logic error;
    logic temperature;
    logic power;
  } fault_set_type;

endpackage

// *** bench/user_logic_model.sv ***
`timescale 1ns/1ps
module user_logic_model (
  // Host side
  input wire logic host_async_reset_in,
  input wire logic frontend_setup_complete_in,
  input wire logic frontend_setup_prepare_in,
  // Bench wishes
  input wire clip_status_pkg::led_pair_type want_in,
  // Toward the block
  output clip_status_pkg::led_pair_type activity_request_out,
  output logic frontend_setup_ready_out
);
  // Quiet while held in reset or clocks not yet valid
  assign activity_request_out = (host_async_reset_in || !frontend_setup_complete_in) ? '0 : want_in;
  assign frontend_setup_ready_out = frontend_setup_prepare_in;
endmodule

// *** bench/tb_clip_led_and_frontend_status.sv ***
`timescale 1ns/1ps
module tb_clip_led_and_frontend_status;
  localparam int STR = 50;
  localparam int SET = 4;
  logic clk_in, rst_n_in, ce, host_rst, sclk, done, prep, rdy, rdy_seen;
  clip_status_pkg::led_pair_type want, req, led;
  clip_status_pkg::fault_set_type fault;
  int bad_count, cmp_count;

  clip_led_and_frontend_status #(.STRETCH(STR), .SETUP(SET), .DIV(5)) i_clip_led_and_frontend_status (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .host_async_reset_in(host_rst),
    .activity_request_in(req), .fault_in(fault), .frontend_setup_ready_in(rdy),
    .activity_led_out(led), .socket_clock_out(sclk), .frontend_setup_complete_out(done),
    .frontend_setup_prepare_out(prep), .frontend_setup_ready_seen_out(rdy_seen));

  user_logic_model i_user_logic_model (
    .host_async_reset_in(host_rst), .frontend_setup_complete_in(done),
    .frontend_setup_prepare_in(prep), .want_in(want),
    .activity_request_out(req), .frontend_setup_ready_out(rdy));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen=%0h exp=%0h", $time, msg, seen, exp);
    end
  endtask

  task conclude;
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Setup pass after a host reset release, then complete holds
  task setup_pass(input logic pulse_host);
    int n;
    n = 0;
    if (pulse_host) begin
      host_rst = 1'b1;
      cyc(6);
      check(done, 1'b0, "complete during host reset");
      host_rst = 1'b0;
    end
    while (done !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 40) begin
        check(0, 1, "setup timeout");
        conclude;
      end
    end
    check(n, SET + 4, "setup length");
    n = 0;
    repeat (30) begin
      cyc(1);
      n += done;
    end
    check(n, 30, "complete held");
    check({prep, rdy_seen}, 2'b00, "handshake idle");
  endtask

  // Four free-running periods: 5 cycles, 2 high
  task socket_run;
    int n, r;
    logic p;
    n = 0;
    r = 0;
    p = sclk;
    repeat (20) begin
      cyc(1);
      n += sclk;
      r += (!p && sclk);
      p = sclk;
    end
    check(n, 8, "socket clock duty");
    check(r, 4, "socket clock period");
  endtask

  // Wait for a socket clock rise, as logic on that clock would
  task socket_align;
    logic p;
    int k;
    p = sclk;
    k = 0;
    cyc(1);
    while (!(p === 1'b0 && sclk === 1'b1)) begin
      p = sclk;
      cyc(1);
      k++;
      if (k > 10) begin
        check(0, 1, "socket clock stuck");
        conclude;
      end
    end
  endtask

  // Clock enable low for 20 cycles freezes socket clock and stretch count
  task freeze_run;
    int n, f;
    logic s;
    n = 0;
    f = 0;
    s = 1'b0;
    for (int k = 0; k < 1000; k++) begin
      want[0] = (k < 10);
      ce = !(k >= 20 && k < 40);
      cyc(1);
      n += led[0];
      if (k == 19) s = sclk;
      if (k >= 20 && k < 40) f += (sclk !== s);
      if (k > 45 && led[0] === 1'b0) break;
    end
    if (led[0] !== 1'b0) begin
      check(0, 1, "freeze timeout");
      conclude;
    end
    check(n, STR + 20, "lit length with freeze");
    check(f, 0, "socket clock frozen");
  endtask

  // Request of len cycles, optional second one gap cycles later
  task stretch_run(input int idx, input int len, input int gap);
    int n, other;
    n = 0;
    other = 0;
    for (int k = 0; k < 1000; k++) begin
      want[idx] = (k < len) || (gap > 0 && k >= gap && k < gap + len);
      cyc(1);
      n += led[idx];
      other += led[1 - idx];
      if (k > gap + len + 5 && led[idx] === 1'b0) break;
    end
    if (led[idx] !== 1'b0) begin
      check(0, 1, "stretch timeout");
      conclude;
    end
    check(n, gap + STR, "lit length");
    check(other, 0, "other indicator quiet");
  endtask

  // Each fault forces red on, green off, then gives back
  task fault_run;
    for (int b = 0; b < 3; b++) begin
      fault = 3'h1 << b;
      cyc(3);
      check(led, 2'h1, "fault override");
      fault = '0;
      cyc(3);
      check(led, 2'h0, "control returned");
    end
  endtask

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    ce = 1'b1;
    host_rst = 1'b0;
    want = '0;
    fault = '0;
    cyc(12);
    rst_n_in = 1'b1;
    setup_pass(1'b0);
    socket_run;
    for (int i = 0; i < 2; i++) begin
      stretch_run(i, 10, 0);
      socket_align;
      stretch_run(i, 5, 0);
      stretch_run(i, 10, 30);
    end
    fault_run;
    freeze_run;
    setup_pass(1'b1);
    setup_pass(1'b1);
    socket_run;
    stretch_run(0, 10, 0);
    conclude;
  end
endmodule
